// ==== common/tcp_pkg.sv ====
package tcp_pkg;

	// Bus geometry
	localparam int          ADDR_W = 8;
	localparam int          DATA_W = 32;

	// Register indices; byte address is four times
	localparam logic [5:0]  IDX_TX_BD_TABLE_BASE         = 6'h00;
	localparam logic [5:0]  IDX_CHANNEL_MODE             = 6'h02;
	localparam logic [5:0]  IDX_TX_INTERNAL_STATE        = 6'h04;
	localparam logic [5:0]  IDX_TX_DATA_POINTER          = 6'h08;
	localparam logic [5:0]  IDX_TX_BD_POINTER            = 6'h0C;
	localparam logic [5:0]  IDX_TX_BYTE_COUNT            = 6'h0E;
	localparam logic [5:0]  IDX_TX_UNPACK_TEMP           = 6'h10;
	localparam logic [5:0]  IDX_ZERO_INSERT_STATE        = 6'h14;
	localparam logic [5:0]  IDX_RESERVED_18              = 6'h18;
	localparam logic [5:0]  IDX_CHANNEL_IRQ_MASK         = 6'h1C;
	localparam logic [5:0]  IDX_DESCRIPTOR_FLAGS_TEMP    = 6'h1E;
	localparam logic [5:0]  IDX_RX_BD_TABLE_BASE         = 6'h20;
	localparam logic [5:0]  IDX_RX_MAX_BUFFER_LENGTH     = 6'h22;
	localparam logic [5:0]  IDX_RX_INTERNAL_STATE        = 6'h24;
	localparam logic [5:0]  IDX_RX_DATA_POINTER          = 6'h28;
	localparam logic [5:0]  IDX_RX_BD_POINTER            = 6'h2C;
	localparam logic [5:0]  IDX_RX_BYTE_COUNT            = 6'h2E;
	localparam logic [5:0]  IDX_RX_PACK_TEMP             = 6'h30;
	localparam logic [5:0]  IDX_ZERO_DELETE_STATE        = 6'h34;
	localparam logic [5:0]  IDX_RESERVED_38              = 6'h38;
	localparam logic [5:0]  IDX_TRANSPARENT_SYNC_CONTROL = 6'h3C;
	localparam logic [5:0]  IDX_RESERVED_3E              = 6'h3E;

	// Reset values
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	localparam logic [15:0] RESET_HALF = 16'h0000;
	localparam logic [7:0]  RESET_BYTE = 8'h00;

	// Field positions
	localparam int          STATE_MOT_BIT = 28;
	localparam int          ZD_HIST_LSB   = 8;
	localparam int          ZD_HIST_MSB   = 23;

	// Stepping
	localparam logic [31:0] WORD_STEP      = 32'h0000_0004;
	localparam logic [15:0] BD_STEP        = 16'h0008;
	localparam logic [2:0]  BYTES_PER_WORD = 3'h4;

	// Byte-strobe merge
	function automatic logic [31:0] apply_strb(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] strb);
		logic [31:0] r;
		r = old_w;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
			begin
				r[8*i +: 8] = new_w[8*i +: 8];
			end
		end
		return r;
	endfunction : apply_strb

endpackage : tcp_pkg

// ==== rtl/tcp_param_ram.sv ====
// Behaviour
// - Tx table base holds 16-bit offset
// - Tx data pointer tracks fetch address
// - Tx descriptor address is base plus pointer
// - Tx byte count holds bytes remaining
// - One fetched word unpacks into up to four bytes, fewer when the byte count is lower
// - Zero-insertion state word, host preloaded
// - Sixteen-bit channel interrupt mask word
// - Rx table base holds 16-bit offset
// - Rx byte count reloads from maximum length at buffer end
// - Rx data pointer tracks store address
// - Rx descriptor address is base plus pointer
// - Rx byte count holds bytes free
// - Four received bytes pack into one word
// - Middle bytes keep 16-bit receive history
// - Transparent sync control word is held
// - Cleared mask bit blocks request and entry
//
// Decided for this implementation: the APB register port.
module tcp_param_ram #(
	parameter logic [15:0] BD_STEP = tcp_pkg::BD_STEP
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [31:0] shared_memory_base,
	input  wire logic        tx_channel_enable,
	input  wire logic        rx_channel_enable,
	output logic             tx_fetch_req,
	output logic      [31:0] tx_fetch_addr,
	input  wire logic        tx_fetch_ack,
	input  wire logic [31:0] tx_fetch_data,
	output logic             tx_byte_valid,
	output logic      [7:0]  tx_byte,
	input  wire logic        tx_byte_take,
	input  wire logic        rx_byte_valid,
	input  wire logic [7:0]  rx_byte,
	output logic             rx_byte_ready,
	output logic             rx_store_req,
	output logic      [31:0] rx_store_addr,
	output logic      [31:0] rx_store_data,
	input  wire logic        rx_store_ack,
	output logic      [31:0] tx_bd_addr,
	output logic      [31:0] rx_bd_addr,
	output logic             rx_buffer_done,
	input  wire logic [15:0] chan_event,
	output logic             event_irq_req,
	output logic             event_queue_we,
	output logic      [15:0] event_queue_bits
);

	logic [15:0] tx_bd_table_base_q;
	logic [15:0] channel_mode_q;
	logic [31:0] tx_internal_state_q;
	logic [31:0] tx_data_pointer_q;
	logic [15:0] tx_bd_pointer_q;
	logic [15:0] tx_byte_count_q;
	logic [31:0] zero_insert_state_q;
	logic [15:0] channel_irq_mask_q;
	logic [15:0] descriptor_flags_temp_q;
	logic [15:0] rx_bd_table_base_q;
	logic [15:0] rx_max_buffer_length_q;
	logic [31:0] rx_internal_state_q;
	logic [31:0] rx_data_pointer_q;
	logic [15:0] rx_bd_pointer_q;
	logic [15:0] rx_byte_count_q;
	logic [31:0] zero_delete_state_q;
	logic [15:0] transparent_sync_control_q;
	logic [31:0] prdata_q;
	logic        pslverr_q;
	logic        tx_fetch_req_q;
	logic [31:0] tx_fetch_addr_q;
	logic        rx_store_req_q;
	logic [31:0] rx_store_addr_q;
	logic [31:0] rx_store_data_q;
	logic        rx_end_q;
	logic        rx_buffer_done_q;
	logic [31:0] tx_bd_addr_q;
	logic [31:0] rx_bd_addr_q;
	logic        event_hit_q;
	logic [15:0] event_bits_q;
	logic        wr_access;
	logic        setup;
	logic [31:0] rd_word;
	logic        rd_mapped;
	logic [31:0] tx_unpack_temp;
	logic [31:0] rx_pack_temp;
	logic        tx_load;
	logic        tx_take;
	logic [2:0]  tx_load_bytes;
	logic        rx_push;
	logic        rx_last;
	logic        rx_word_done;
	logic [15:0] event_masked;

	// Aligned hit on a register index
	function automatic logic hit(input logic [7:0] a, input logic [5:0] idx);
		return (a[1:0] == 2'b00) && (a[7:2] == idx);
	endfunction : hit

	// Strobed half-width update
	function automatic logic [15:0] half_wr(input logic [15:0] old_h,
		input logic [31:0] wd, input logic [3:0] st);
		logic [31:0] m;
		m = tcp_pkg::apply_strb({16'h0000, old_h}, wd, st);
		return m[15:0];
	endfunction : half_wr

	// Zero-wait slave
	assign setup     = psel && !penable;
	assign wr_access = psel && penable && pwrite;
	assign pready    = 1'b1;
	assign pslverr   = psel && penable && pslverr_q;
	assign prdata    = prdata_q;

	// Read mux; reserved words read zero, holes are errors
	always_comb
	begin
		rd_word   = tcp_pkg::RESET_WORD;
		rd_mapped = (paddr[1:0] == 2'b00);
		case (paddr[7:2])
			tcp_pkg::IDX_TX_BD_TABLE_BASE: rd_word = {16'h0000, tx_bd_table_base_q};
			tcp_pkg::IDX_CHANNEL_MODE: rd_word = {16'h0000, channel_mode_q};
			tcp_pkg::IDX_TX_INTERNAL_STATE: rd_word = tx_internal_state_q;
			tcp_pkg::IDX_TX_DATA_POINTER: rd_word = tx_data_pointer_q;
			tcp_pkg::IDX_TX_BD_POINTER: rd_word = {16'h0000, tx_bd_pointer_q};
			tcp_pkg::IDX_TX_BYTE_COUNT: rd_word = {16'h0000, tx_byte_count_q};
			tcp_pkg::IDX_TX_UNPACK_TEMP: rd_word = tx_unpack_temp;
			tcp_pkg::IDX_ZERO_INSERT_STATE: rd_word = zero_insert_state_q;
			tcp_pkg::IDX_RESERVED_18: rd_word = tcp_pkg::RESET_WORD;
			tcp_pkg::IDX_CHANNEL_IRQ_MASK: rd_word = {16'h0000, channel_irq_mask_q};
			tcp_pkg::IDX_DESCRIPTOR_FLAGS_TEMP: rd_word = {16'h0000, descriptor_flags_temp_q};
			tcp_pkg::IDX_RX_BD_TABLE_BASE: rd_word = {16'h0000, rx_bd_table_base_q};
			tcp_pkg::IDX_RX_MAX_BUFFER_LENGTH: rd_word = {16'h0000, rx_max_buffer_length_q};
			tcp_pkg::IDX_RX_INTERNAL_STATE: rd_word = rx_internal_state_q;
			tcp_pkg::IDX_RX_DATA_POINTER: rd_word = rx_data_pointer_q;
			tcp_pkg::IDX_RX_BD_POINTER: rd_word = {16'h0000, rx_bd_pointer_q};
			tcp_pkg::IDX_RX_BYTE_COUNT: rd_word = {16'h0000, rx_byte_count_q};
			tcp_pkg::IDX_RX_PACK_TEMP: rd_word = rx_pack_temp;
			tcp_pkg::IDX_ZERO_DELETE_STATE: rd_word = zero_delete_state_q;
			tcp_pkg::IDX_RESERVED_38: rd_word = tcp_pkg::RESET_WORD;
			tcp_pkg::IDX_TRANSPARENT_SYNC_CONTROL: rd_word = {16'h0000, transparent_sync_control_q};
			tcp_pkg::IDX_RESERVED_3E: rd_word = tcp_pkg::RESET_WORD;
			default: rd_mapped = 1'b0;
		endcase
	end

	// Read answer flopped in setup
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_q  <= tcp_pkg::RESET_WORD;
			pslverr_q <= 1'b0;
		end
		else if (setup)
		begin
			prdata_q  <= pwrite ? tcp_pkg::RESET_WORD : (rd_mapped ? rd_word : tcp_pkg::RESET_WORD);
			pslverr_q <= !rd_mapped;
		end
	end

	// Host-only words
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_bd_table_base_q         <= tcp_pkg::RESET_HALF;
			channel_mode_q             <= tcp_pkg::RESET_HALF;
			tx_internal_state_q        <= tcp_pkg::RESET_WORD;
			zero_insert_state_q        <= tcp_pkg::RESET_WORD;
			channel_irq_mask_q         <= tcp_pkg::RESET_HALF;
			descriptor_flags_temp_q    <= tcp_pkg::RESET_HALF;
			rx_bd_table_base_q         <= tcp_pkg::RESET_HALF;
			rx_max_buffer_length_q     <= tcp_pkg::RESET_HALF;
			rx_internal_state_q        <= tcp_pkg::RESET_WORD;
			transparent_sync_control_q <= tcp_pkg::RESET_HALF;
		end
		else if (wr_access && !pslverr_q)
		begin
			if (hit(paddr, tcp_pkg::IDX_TX_BD_TABLE_BASE))
				tx_bd_table_base_q <= half_wr(tx_bd_table_base_q, pwdata, pstrb);
			if (hit(paddr, tcp_pkg::IDX_CHANNEL_MODE))
				channel_mode_q <= half_wr(channel_mode_q, pwdata, pstrb);
			if (hit(paddr, tcp_pkg::IDX_TX_INTERNAL_STATE))
				tx_internal_state_q <= tcp_pkg::apply_strb(tx_internal_state_q, pwdata, pstrb);
			if (hit(paddr, tcp_pkg::IDX_ZERO_INSERT_STATE))
				zero_insert_state_q <= tcp_pkg::apply_strb(zero_insert_state_q, pwdata, pstrb);
			if (hit(paddr, tcp_pkg::IDX_CHANNEL_IRQ_MASK))
				channel_irq_mask_q <= half_wr(channel_irq_mask_q, pwdata, pstrb);
			if (hit(paddr, tcp_pkg::IDX_DESCRIPTOR_FLAGS_TEMP))
				descriptor_flags_temp_q <= half_wr(descriptor_flags_temp_q, pwdata, pstrb);
			if (hit(paddr, tcp_pkg::IDX_RX_BD_TABLE_BASE))
				rx_bd_table_base_q <= half_wr(rx_bd_table_base_q, pwdata, pstrb);
			if (hit(paddr, tcp_pkg::IDX_RX_MAX_BUFFER_LENGTH))
				rx_max_buffer_length_q <= half_wr(rx_max_buffer_length_q, pwdata, pstrb);
			if (hit(paddr, tcp_pkg::IDX_RX_INTERNAL_STATE))
				rx_internal_state_q <= tcp_pkg::apply_strb(rx_internal_state_q, pwdata, pstrb);
			if (hit(paddr, tcp_pkg::IDX_TRANSPARENT_SYNC_CONTROL))
				transparent_sync_control_q <= half_wr(transparent_sync_control_q, pwdata,
					pstrb);
		end
	end

	// Fetch once the unpacker drains
	assign tx_load       = tx_fetch_req_q && tx_fetch_ack;
	assign tx_take       = tx_byte_valid && tx_byte_take;
	assign tx_load_bytes = (tx_byte_count_q > 16'h0004) ? tcp_pkg::BYTES_PER_WORD
		: tx_byte_count_q[2:0];

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_fetch_req_q  <= 1'b0;
			tx_fetch_addr_q <= tcp_pkg::RESET_WORD;
		end
		else if (tx_load)
		begin
			tx_fetch_req_q <= 1'b0;
		end
		else if (!tx_fetch_req_q && tx_channel_enable && tx_byte_count_q != 16'h0000
			&& !tx_byte_valid)
		begin
			tx_fetch_req_q  <= 1'b1;
			tx_fetch_addr_q <= tx_data_pointer_q;
		end
	end

	// Host write beats a hardware step
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_data_pointer_q <= tcp_pkg::RESET_WORD;
			tx_byte_count_q   <= tcp_pkg::RESET_HALF;
			tx_bd_pointer_q   <= tcp_pkg::RESET_HALF;
		end
		else
		begin
			if (wr_access && hit(paddr, tcp_pkg::IDX_TX_DATA_POINTER))
				tx_data_pointer_q <= tcp_pkg::apply_strb(tx_data_pointer_q, pwdata, pstrb);
			else if (tx_load)
				tx_data_pointer_q <= tx_data_pointer_q + tcp_pkg::WORD_STEP;
			if (wr_access && hit(paddr, tcp_pkg::IDX_TX_BYTE_COUNT))
				tx_byte_count_q <= half_wr(tx_byte_count_q, pwdata, pstrb);
			else if (tx_take && tx_byte_count_q != 16'h0000)
				tx_byte_count_q <= tx_byte_count_q - 16'h0001;
			if (wr_access && hit(paddr, tcp_pkg::IDX_TX_BD_POINTER))
				tx_bd_pointer_q <= half_wr(tx_bd_pointer_q, pwdata, pstrb);
		end
	end

	tcp_tx_unpack u_tx_unpack (
		.clk        (pclk),
		.rst_n      (presetn),
		.load       (tx_load),
		.load_word  (tx_fetch_data),
		.load_bytes (tx_load_bytes),
		.host_we    (wr_access && hit(paddr, tcp_pkg::IDX_TX_UNPACK_TEMP)),
		.host_word  (pwdata),
		.big_endian (tx_internal_state_q[tcp_pkg::STATE_MOT_BIT]),
		.take       (tx_take),
		.temp       (tx_unpack_temp),
		.byte_out   (tx_byte),
		.byte_valid (tx_byte_valid)
	);

	// Rx stalls while a store is pending
	assign rx_byte_ready = rx_channel_enable && !rx_store_req_q && !rx_word_done
		&& !rx_end_q && rx_byte_count_q != 16'h0000;
	assign rx_push       = rx_byte_valid && rx_byte_ready;
	assign rx_last       = (rx_byte_count_q == 16'h0001);

	tcp_rx_pack u_rx_pack (
		.clk        (pclk),
		.rst_n      (presetn),
		.push       (rx_push),
		.push_byte  (rx_byte),
		.flush      (rx_last),
		.big_endian (rx_internal_state_q[tcp_pkg::STATE_MOT_BIT]),
		.host_we    (wr_access && hit(paddr, tcp_pkg::IDX_RX_PACK_TEMP)),
		.host_word  (pwdata),
		.temp       (rx_pack_temp),
		.word_done  (rx_word_done)
	);

	// Latch packed word for the store
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_store_req_q  <= 1'b0;
			rx_store_addr_q <= tcp_pkg::RESET_WORD;
			rx_store_data_q <= tcp_pkg::RESET_WORD;
			rx_end_q        <= 1'b0;
		end
		else
		begin
			if (rx_word_done)
			begin
				rx_store_req_q  <= 1'b1;
				rx_store_addr_q <= rx_data_pointer_q;
				rx_store_data_q <= rx_pack_temp;
			end
			else if (rx_store_ack)
				rx_store_req_q <= 1'b0;
			if (rx_push && rx_last)
				rx_end_q <= 1'b1;
			else if (rx_store_req_q && rx_store_ack)
				rx_end_q <= 1'b0;
		end
	end

	// Full buffer moves to the next descriptor
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_data_pointer_q <= tcp_pkg::RESET_WORD;
			rx_bd_pointer_q   <= tcp_pkg::RESET_HALF;
			rx_byte_count_q   <= tcp_pkg::RESET_HALF;
			rx_buffer_done_q  <= 1'b0;
		end
		else
		begin
			rx_buffer_done_q <= rx_store_req_q && rx_store_ack && rx_end_q;
			if (wr_access && hit(paddr, tcp_pkg::IDX_RX_DATA_POINTER))
				rx_data_pointer_q <= tcp_pkg::apply_strb(rx_data_pointer_q, pwdata, pstrb);
			else if (rx_store_req_q && rx_store_ack)
				rx_data_pointer_q <= rx_data_pointer_q + tcp_pkg::WORD_STEP;
			if (wr_access && hit(paddr, tcp_pkg::IDX_RX_BD_POINTER))
				rx_bd_pointer_q <= half_wr(rx_bd_pointer_q, pwdata, pstrb);
			else if (rx_store_req_q && rx_store_ack && rx_end_q)
				rx_bd_pointer_q <= rx_bd_pointer_q + BD_STEP;
			if (wr_access && hit(paddr, tcp_pkg::IDX_RX_BYTE_COUNT))
				rx_byte_count_q <= half_wr(rx_byte_count_q, pwdata, pstrb);
			else if (rx_store_req_q && rx_store_ack && rx_end_q)
				rx_byte_count_q <= rx_max_buffer_length_q;
			else if (rx_push)
				rx_byte_count_q <= rx_byte_count_q - 16'h0001;
		end
	end

	// 16-bit receive history, middle bytes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			zero_delete_state_q <= tcp_pkg::RESET_WORD;
		else if (wr_access && hit(paddr, tcp_pkg::IDX_ZERO_DELETE_STATE))
			zero_delete_state_q <= tcp_pkg::apply_strb(zero_delete_state_q, pwdata,
				pstrb);
		else if (rx_push)
			zero_delete_state_q[tcp_pkg::ZD_HIST_MSB:tcp_pkg::ZD_HIST_LSB] <=
				{zero_delete_state_q[15:8], rx_byte};
	end

	// Registered to keep adders off the pins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_bd_addr_q <= tcp_pkg::RESET_WORD;
			rx_bd_addr_q <= tcp_pkg::RESET_WORD;
		end
		else
		begin
			tx_bd_addr_q <= shared_memory_base + {16'h0000, tx_bd_pointer_q};
			rx_bd_addr_q <= shared_memory_base + {16'h0000, rx_bd_pointer_q};
		end
	end

	// Cleared mask bit: no request, no entry
	assign event_masked = chan_event & channel_irq_mask_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			event_hit_q  <= 1'b0;
			event_bits_q <= tcp_pkg::RESET_HALF;
		end
		else
		begin
			event_hit_q <= (event_masked != 16'h0000);
			if (event_masked != 16'h0000)
				event_bits_q <= event_masked;
		end
	end

	assign tx_fetch_req     = tx_fetch_req_q;
	assign tx_fetch_addr    = tx_fetch_addr_q;
	assign rx_store_req     = rx_store_req_q;
	assign rx_store_addr    = rx_store_addr_q;
	assign rx_store_data    = rx_store_data_q;
	assign tx_bd_addr       = tx_bd_addr_q;
	assign rx_bd_addr       = rx_bd_addr_q;
	assign rx_buffer_done   = rx_buffer_done_q;
	assign event_irq_req    = event_hit_q;
	assign event_queue_we   = event_hit_q;
	assign event_queue_bits = event_bits_q;

endmodule : tcp_param_ram

// ==== rtl/tcp_rx_pack.sv ====
module tcp_rx_pack (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        push,
	input  wire logic [7:0]  push_byte,
	input  wire logic        flush,
	input  wire logic        big_endian,
	input  wire logic        host_we,
	input  wire logic [31:0] host_word,
	output logic      [31:0] temp,
	output logic             word_done
);

	logic [31:0] temp_q;
	logic [1:0]  fill_q;
	logic        done_q;
	logic [1:0]  lane;

	// Big-endian puts the first byte in the top lane
	assign lane = big_endian ? (2'h3 - fill_q) : fill_q;

	// Four bytes or a tail make a word
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			temp_q <= tcp_pkg::RESET_WORD;
			fill_q <= 2'h0;
			done_q <= 1'b0;
		end
		else
		begin
			done_q <= 1'b0;
			if (push)
			begin
				temp_q[8*lane +: 8] <= push_byte;
				fill_q <= (fill_q == 2'h3 || flush) ? 2'h0 : fill_q + 2'h1;
				done_q <= (fill_q == 2'h3) || flush;
			end
			else if (host_we)
			begin
				temp_q <= host_word;
				fill_q <= 2'h0;
			end
		end
	end

	assign temp      = temp_q;
	assign word_done = done_q;

endmodule : tcp_rx_pack

// ==== rtl/tcp_tx_unpack.sv ====
module tcp_tx_unpack (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        load,
	input  wire logic [31:0] load_word,
	input  wire logic [2:0]  load_bytes,
	input  wire logic        host_we,
	input  wire logic [31:0] host_word,
	input  wire logic        big_endian,
	input  wire logic        take,
	output logic      [31:0] temp,
	output logic      [7:0]  byte_out,
	output logic             byte_valid
);

	logic [31:0] temp_q;
	logic [2:0]  left_q;
	logic [1:0]  idx_q;
	logic [7:0]  byte_q;

	// Byte lane for a position
	function automatic logic [7:0] pick(input logic [31:0] w, input logic [1:0] i,
		input logic be);
		logic [1:0] lane;
		lane = be ? (2'h3 - i) : i;
		return w[8*lane +: 8];
	endfunction : pick

	// Load beats a host write; host write stores the word and drops pending bytes
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			temp_q <= tcp_pkg::RESET_WORD;
			left_q <= 3'h0;
			idx_q  <= 2'h0;
			byte_q <= tcp_pkg::RESET_BYTE;
		end
		else if (load)
		begin
			temp_q <= load_word;
			left_q <= load_bytes;
			idx_q  <= 2'h0;
			byte_q <= pick(load_word, 2'h0, big_endian);
		end
		else if (host_we)
		begin
			temp_q <= host_word;
			left_q <= 3'h0;
		end
		else if (take && left_q != 3'h0)
		begin
			left_q <= left_q - 3'h1;
			idx_q  <= idx_q + 2'h1;
			byte_q <= pick(temp_q, idx_q + 2'h1, big_endian);
		end
	end

	assign temp       = temp_q;
	assign byte_out   = byte_q;
	assign byte_valid = (left_q != 3'h0);

endmodule : tcp_tx_unpack

// ==== verif/tb.sv ====
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk, presetn, psel, penable, pwrite, tx_channel_enable, rx_channel_enable;
	logic        tx_byte_take, rx_byte_valid, tx_fetch_req, tx_fetch_ack, tx_byte_valid, err_q;
	logic        pready, pslverr, rx_byte_ready, rx_store_req, rx_store_ack, rx_buffer_done;
	logic        event_irq_req, event_queue_we;
	logic [2:0]  delay;
	logic [3:0]  pstrb;
	logic [7:0]  paddr, tx_byte, rx_byte;
	logic [15:0] chan_event, event_queue_bits, ev, lb;
	logic [31:0] pwdata, prdata, shared_memory_base, tx_fetch_addr, tx_fetch_data, tw, acc;
	logic [31:0] rx_store_addr, rx_store_data, tx_bd_addr, rx_bd_addr, lf, rd_q, sa;
	logic [31:0] exp_q [19];
	logic [31:0] wq [$];
	int          fail_count, compares, k;
	localparam logic [7:0] IX [19] = '{8'h00, 8'h02, 8'h04, 8'h08, 8'h0C, 8'h0E, 8'h10, 8'h14,
		8'h1C, 8'h1E, 8'h20, 8'h22, 8'h24, 8'h28, 8'h2C, 8'h2E, 8'h30, 8'h34, 8'h3C};
	tcp_param_ram DUT (.*);
	tcp_mem_model u_mem (.*);
	// Clock
	initial
	begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nx
	// Half-word registers by index
	function automatic logic w16(input logic [7:0] x);
		return x[1] || x[3:2] == 2'h3 || x[4:0] == 5'h00;
	endfunction : w16
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask : chk
	// Idle edge first
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do @(posedge pclk); while (pready !== 1'b1 && ++k < 50);
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic ee);
		apb(1'b0, a, 32'h0);
		chk("prdata", e, rd_q);
		chk("pslverr", {31'h0, ee}, {31'h0, err_q});
	endtask : rd
	task automatic test_done;
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : test_done
	// Completed stores
	always @(negedge pclk)
		if (rx_store_req === 1'b1 && rx_store_ack === 1'b1)
		begin
			chk("rx_store_addr", sa, rx_store_addr);
			chk("rx_store_data", wq.pop_front(), rx_store_data);
			sa = sa + 32'h0000_0004;
		end
	// Run needs a few hundred cycles
	initial
	begin
		repeat (20000) @(posedge pclk);
		fail_count++;
		test_done();
	end
	initial
	begin
		{psel, penable, pwrite, tx_channel_enable, rx_channel_enable, presetn} = 6'h00;
		{tx_byte_take, rx_byte_valid, paddr, rx_byte, chan_event, lb} = 50'h0;
		{pwdata, shared_memory_base, pstrb, delay, lf} = {64'h0, 4'hF, 3'h0, 32'h0000_0027};
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		// Reset and random images
		foreach (IX[i])
			rd({IX[i][5:0], 2'h0}, 32'h0, 1'b0);
		foreach (IX[i])
		begin
			lf = nx(lf);
			exp_q[i] = w16(IX[i]) ? lf & 32'h0000_FFFF : lf;
			apb(1'b1, {IX[i][5:0], 2'h0}, lf);
		end
		foreach (IX[i])
			rd({IX[i][5:0], 2'h0}, exp_q[i], 1'b0);
		apb(1'b1, 8'h60, 32'hFFFF_FFFF);
		rd(8'h60, 32'h0, 1'b0);
		rd(8'h05, 32'h0, 1'b1);
		rd(8'h04, 32'h0, 1'b1);
		// Six tx bytes, high lane first
		delay <= 3'h2;
		shared_memory_base <= lf;
		apb(1'b1, 8'h20, 32'h0000_1000);
		apb(1'b1, 8'h38, 32'h0000_0006);
		apb(1'b1, 8'h10, 32'h3800_0000);
		apb(1'b1, 8'h00, 32'h0000_0100);
		apb(1'b1, 8'h30, 32'h0000_0100);
		tx_channel_enable <= 1'b1;
		for (int i = 0; i < 6; i++)
		begin
			k = 0;
			do @(negedge pclk); while (tx_byte_valid !== 1'b1 && ++k < 50);
			tw = (32'h0000_1000 + 4 * (i / 4)) ^ 32'hA5C3_0F96;
			chk("tx_byte", {24'h0, tw[31 - 8 * (i % 4) -: 8]}, {24'h0, tx_byte});
			@(posedge pclk) tx_byte_take <= 1'b1;
			@(posedge pclk) tx_byte_take <= 1'b0;
		end
		rd(8'h38, 32'h0, 1'b0);
		rd(8'h20, 32'h0000_1008, 1'b0);
		chk("tx_bd_addr", shared_memory_base + 32'h0000_0100, tx_bd_addr);
		// Eight rx bytes, slow stores
		tx_channel_enable <= 1'b0;
		delay <= 3'h3;
		sa = 32'h0000_2000;
		apb(1'b1, 8'h88, 32'h0000_0008);
		apb(1'b1, 8'hB8, 32'h0000_0008);
		apb(1'b1, 8'hA0, sa);
		apb(1'b1, 8'h80, 32'h0000_0040);
		apb(1'b1, 8'hB0, 32'h0000_0040);
		apb(1'b1, 8'h90, 32'h3900_0000);
		apb(1'b1, 8'hD0, 32'h1800_0080);
		rx_channel_enable <= 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			lf = nx(lf);
			acc = {acc[23:0], lf[7:0]};
			if (i % 4 == 3)
				wq.push_back(acc);
			@(posedge pclk) rx_byte_valid <= 1'b1;
			rx_byte <= lf[7:0];
			k = 0;
			do @(negedge pclk); while (rx_byte_ready !== 1'b1 && ++k < 50);
			@(posedge pclk) rx_byte_valid <= 1'b0;
		end
		k = 0;
		do @(negedge pclk); while (rx_buffer_done !== 1'b1 && ++k < 50);
		chk("rx_buffer_done", 32'h1, {31'h0, rx_buffer_done});
		rx_channel_enable <= 1'b0;
		rd(8'hB0, 32'h0000_0048, 1'b0);
		rd(8'hB8, 32'h0000_0008, 1'b0);
		rd(8'hA0, 32'h0000_2008, 1'b0);
		rd(8'hD0, {8'h18, acc[15:0], 8'h80}, 1'b0);
		chk("rx_bd_addr", shared_memory_base + 32'h0000_0048, rx_bd_addr);
		// Random events, even ones masked
		lf = nx(lf);
		tw = {16'h0, lf[15:0]};
		apb(1'b1, 8'h70, tw);
		for (int i = 0; i < 16; i++)
		begin
			lf = nx(lf);
			ev = i[0] ? lf[15:0] : lf[15:0] & ~tw[15:0];
			lb = (ev & tw[15:0]) != 16'h0 ? ev & tw[15:0] : lb;
			@(posedge pclk) chan_event <= ev;
			@(posedge pclk) chan_event <= 16'h0;
			@(negedge pclk);
			chk("event_irq_req", {31'h0, |(ev & tw[15:0])}, {31'h0, event_irq_req});
			chk("event_queue_bits", {16'h0, lb}, {16'h0, event_queue_bits});
		end
		test_done();
	end
endmodule : tb

// ==== verif/tcp_mem_model.sv ====
module tcp_mem_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [2:0]  delay,
	input  wire logic        tx_fetch_req,
	input  wire logic [31:0] tx_fetch_addr,
	output logic             tx_fetch_ack,
	output logic      [31:0] tx_fetch_data,
	input  wire logic        rx_store_req,
	output logic             rx_store_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] wait_q;
	// Fetch wins a tie
	assign tx_fetch_ack = tx_fetch_req && wait_q == delay;
	assign rx_store_ack = rx_store_req && !tx_fetch_req && wait_q == delay;
	// Address hash on ack, inverted address otherwise
	assign tx_fetch_data = tx_fetch_ack ? tx_fetch_addr ^ 32'hA5C3_0F96 : ~tx_fetch_addr;
	wire busy = (tx_fetch_req && !tx_fetch_ack) || (rx_store_req && !rx_store_ack);
	// Answer delay counter
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			wait_q <= 3'h0;
		else
			wait_q <= busy ? wait_q + 3'h1 : 3'h0;
endmodule : tcp_mem_model

// ==== verif/tcp_monitor.sv ====
module tcp_monitor (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        tx_fetch_req,
	input wire logic [31:0] tx_fetch_addr,
	input wire logic        tx_fetch_ack,
	input wire logic        tx_byte_valid,
	input wire logic        rx_byte_ready,
	input wire logic        rx_store_req,
	input wire logic [31:0] rx_store_addr,
	input wire logic [31:0] rx_store_data,
	input wire logic        rx_store_ack,
	input wire logic        rx_buffer_done,
	input wire logic [15:0] chan_event,
	input wire logic        event_irq_req,
	input wire logic        event_queue_we,
	input wire logic [15:0] event_queue_bits
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] fa_q;
	logic [31:0] sa_q;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence f_wait; tx_fetch_req && !tx_fetch_ack; endsequence
	sequence f_done; tx_fetch_req && tx_fetch_ack; endsequence
	sequence s_wait; rx_store_req && !rx_store_ack; endsequence
	// Last answered addresses, zero if none
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			{fa_q, sa_q} <= 64'h0;
		else if (tx_fetch_req && tx_fetch_ack)
			fa_q <= tx_fetch_addr;
		else if (rx_store_req && rx_store_ack)
			sa_q <= rx_store_addr;
	fetch_hold_a: assert property (f_wait |=> tx_fetch_req && $stable(tx_fetch_addr))
		else $error("fetch not held");
	fetch_step_a: assert property ($rose(tx_fetch_req) && fa_q != 32'h0 |->
		tx_fetch_addr == fa_q + 32'h0000_0004) else $error("fetch step");
	unpack_a: assert property (f_done |=> tx_byte_valid)
		else $error("no byte");
	store_hold_a: assert property (s_wait |=> rx_store_req && $stable(rx_store_data)
		&& $stable(rx_store_addr)) else $error("store not held");
	store_block_a: assert property (s_wait |-> !rx_byte_ready)
		else $error("byte during store");
	store_step_a: assert property ($rose(rx_store_req) && sa_q != 32'h0 |->
		rx_store_addr == sa_q + 32'h0000_0004) else $error("store step");
	buf_done_a: assert property (rx_buffer_done |-> $past(rx_store_ack) && $past(rx_store_req))
		else $error("stray buffer end");
	irq_cause_a: assert property (event_irq_req |-> $past(chan_event) != 16'h0000
		&& (event_queue_bits & ~$past(chan_event)) == 16'h0000) else $error("stray irq");
	irq_pair_a: assert property (event_queue_we == event_irq_req
		&& (!event_queue_we || event_queue_bits != 16'h0000)) else $error("entry mismatch");
endmodule : tcp_monitor
bind tcp_param_ram tcp_monitor u_mon (.*);
